// *** hdl/dsq_pkg.sv ***
package dsq_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  // Figures for the slower grade, which also satisfy the faster grade.
  localparam int T_RAS_NS      = 200;
  localparam int T_RP_NS       = 120;
  localparam int T_RCD_NS      = 25;
  localparam int T_CAS_NS      = 135;
  localparam int T_CP_NS       = 80;
  localparam int T_PC_NS       = 225;
  localparam int T_RC_NS       = 375;
  localparam int T_RMW_NS      = 405;
  localparam int T_CWD_NS      = 80;
  localparam int T_RWD_NS      = 145;
  localparam int T_WP_NS       = 55;
  localparam int T_CWL_NS      = 70;
  localparam int T_ASC_NS      = 0;
  localparam int T_REF_MS      = 2;
  localparam int ROWS          = 128;
  localparam int WARMUP_CYCLES = 8;
  localparam int REF_MARGIN    = 2;
  localparam int T_RAC_NS      = 200;
  localparam int T_CAC_NS      = 135;
  localparam int T_RAS_MAX_NS  = 10000;
  // Page accesses stop early so the last one still ends inside the limit.
  localparam int T_PAGE_END_NS = 9000;
  // Edges from a data-out change until the response register can take it from the third sync flop.
  localparam int SYNC_LAT      = 4;

  function automatic int ns_up(input int ns);
    return (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction

  localparam int C_RCD   = ns_up(T_RCD_NS) + 1;
  localparam int C_CAS   = ns_up(T_CAS_NS);
  localparam int C_CP    = ns_up(T_CP_NS);
  localparam int C_RP    = ns_up(T_RP_NS);
  localparam int C_RAS   = ns_up(T_RAS_NS);
  localparam int C_RC    = ns_up(T_RC_NS);
  localparam int C_RMW   = ns_up(T_RMW_NS);
  localparam int C_PC    = ns_up(T_PC_NS);
  localparam int C_CWD   = ns_up(T_CWD_NS) + 1;
  localparam int C_RWD   = ns_up(T_RWD_NS) + 1;
  localparam int C_WP    = ns_up(T_WP_NS);
  localparam int C_CWL   = ns_up(T_CWL_NS);
  localparam int C_RAC_SMP = ns_up(T_RAC_NS) + SYNC_LAT;
  localparam int C_CAC_SMP = ns_up(T_CAC_NS) + SYNC_LAT;
  localparam int C_RAS_MAX = ns_up(T_RAS_MAX_NS);
  localparam int C_PAGE_END = ns_up(T_PAGE_END_NS);
  // Refresh period as cycles, rounded down, divided across rows with margin.
  localparam int C_REF_ROW = (T_REF_MS * 1000000 * 1000 / CLK_PERIOD_PS)
                             / (ROWS * REF_MARGIN);
  localparam int CW      = 12;

  typedef enum logic [1:0] {
    DSQ_OP_READ,
    DSQ_OP_WRITE,
    DSQ_OP_RMW
  } dsq_op_e;
endpackage

// *** hdl/dsq_tmr_if.sv ***
interface dsq_tmr_if;
  import dsq_pkg::*;
  logic          load;
  logic [CW-1:0] value;
  logic          done;
  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface

// *** hdl/dsq_timer.sv ***
module dsq_timer
  import dsq_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic resetn_i,
  dsq_tmr_if.tmr    t
);
  logic [CW-1:0] cnt_q;

  // ---------------------------------------------------------------
  // Down counter
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
    end else if (t.load) begin
      cnt_q <= t.value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Done must not look at load, since the loader itself decides on done.
  assign t.done = (cnt_q == '0);
endmodule

// *** hdl/dsq_ctrl.sv ***
module dsq_ctrl
  import dsq_pkg::*;
#(
  parameter int REF_ROW_CYCLES = C_REF_ROW
) (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        req_valid_i,
  input  wire logic [1:0]  req_op_i,
  input  wire logic [13:0] req_addr_i,
  input  wire logic        req_wdata_i,
  input  wire logic        req_page_i,
  output logic             req_ready_o,
  output logic             rsp_valid_o,
  output logic             rsp_rdata_o,
  output logic             ready_o,
  output logic             row_strobe_n_o,
  output logic             col_strobe_n_o,
  output logic             write_n_o,
  output logic [6:0]       addr_o,
  output logic             din_o,
  input  wire logic        dout_i
);
  if (REF_ROW_CYCLES < 1 || REF_ROW_CYCLES >= (1 << 24)) begin : g_bad_ref
    $error("REF_ROW_CYCLES out of range");
  end

  // A read-modify-write waits until the read bit has passed the synchroniser.
  function automatic logic [CW-1:0] col_wait(input logic [1:0] k);
    if (k == 2'(DSQ_OP_WRITE)) begin
      return CW'(C_CAS);
    end else if (k == 2'(DSQ_OP_RMW)) begin
      return CW'(C_CAC_SMP);
    end
    return CW'(C_CWD);
  endfunction

  typedef enum logic [3:0] {
    S_IDLE, S_RCD, S_CAS, S_WLATE, S_WHOLD, S_CEND, S_PAGE, S_RPRE, S_REF
  } dsq_state_e;

  dsq_state_e    state_q;
  dsq_tmr_if     tm ();
  logic [CW-1:0] cyc_q;
  logic [23:0]   ref_cnt_q;
  logic          ref_due_q;
  logic [6:0]    ref_row_q;
  logic [3:0]    warm_q;
  logic [1:0]    op_q;
  logic          s1_q, s2_q, s3_q;
  logic          is_ref;
  logic          wlate_go;
  logic          cend_go;
  logic          page_go;

  dsq_timer u_tmr (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .t        (tm)
  );

  // ---------------------------------------------------------------
  // Data input synchroniser
  // ---------------------------------------------------------------
  // The sample is taken well after access time, so three flops are fine.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= dout_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ---------------------------------------------------------------
  // Refresh scheduling
  // ---------------------------------------------------------------
  assign is_ref = (state_q == S_REF);

  assign wlate_go = tm.done && (op_q != 2'(DSQ_OP_RMW)
                    || (cyc_q >= CW'(C_RAC_SMP)
                        && cyc_q >= CW'(C_RWD)));
  assign cend_go  = tm.done && cyc_q >= CW'(C_RAC_SMP)
                    && (state_q == S_WHOLD || op_q == 2'(DSQ_OP_WRITE));
  assign page_go  = tm.done && req_valid_i && req_page_i && !ref_due_q
                    && cyc_q < CW'(C_PAGE_END);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_cnt_q <= '0;
      ref_due_q <= 1'b1;
    end else begin
      if (ref_cnt_q == 24'(REF_ROW_CYCLES - 1)) begin
        ref_cnt_q <= '0;
        ref_due_q <= 1'b1;
      end else begin
        ref_cnt_q <= ref_cnt_q + 1'b1;
        if (is_ref && tm.done) begin
          ref_due_q <= (warm_q != 4'h0);
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      warm_q    <= 4'(WARMUP_CYCLES);
      ref_row_q <= '0;
    end else if (is_ref && tm.done) begin
      ref_row_q <= ref_row_q + 1'b1;
      if (warm_q != 4'h0) begin
        warm_q <= warm_q - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Cycle length counter
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cyc_q <= '0;
    end else if (state_q == S_IDLE) begin
      cyc_q <= '0;
    end else if (cyc_q != '1) begin
      cyc_q <= cyc_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Timer loads
  // ---------------------------------------------------------------
  always_comb begin
    tm.load  = 1'b0;
    tm.value = '0;
    case (state_q)
      S_IDLE: begin
        if (ref_due_q || (req_valid_i && warm_q == 4'h0)) begin
          tm.load  = 1'b1;
          tm.value = ref_due_q ? CW'(C_RAS) : CW'(C_RCD);
        end
      end
      S_RCD: begin
        if (tm.done) begin
          tm.load  = 1'b1;
          tm.value = col_wait(op_q);
        end
      end
      S_WLATE: begin
        if (wlate_go) begin
          tm.load  = 1'b1;
          tm.value = CW'(C_CWL);
        end
      end
      S_CAS, S_WHOLD: begin
        if (cend_go) begin
          tm.load  = 1'b1;
          tm.value = CW'(C_CP);
        end
      end
      S_CEND: begin
        tm.load  = 1'b1;
        tm.value = CW'(C_RP);
      end
      S_PAGE: begin
        if (page_go) begin
          tm.load  = 1'b1;
          tm.value = col_wait(req_op_i);
        end
      end
      S_REF: begin
        if (tm.done) begin
          tm.load  = 1'b1;
          tm.value = CW'(C_RP);
        end
      end
      default: begin
        tm.load  = 1'b0;
        tm.value = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer and pins
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q        <= S_IDLE;
      op_q           <= '0;
      row_strobe_n_o <= 1'b1;
      col_strobe_n_o <= 1'b1;
      write_n_o      <= 1'b1;
      addr_o         <= '0;
      din_o          <= 1'b0;
      req_ready_o    <= 1'b0;
      rsp_valid_o    <= 1'b0;
      rsp_rdata_o    <= 1'b0;
      ready_o        <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      req_ready_o <= 1'b0;
      ready_o     <= (warm_q == 4'h0);
      case (state_q)
        S_IDLE: begin
          if (ref_due_q) begin
            addr_o         <= ref_row_q;
            row_strobe_n_o <= 1'b0;
            state_q        <= S_REF;
          end else if (req_valid_i && warm_q == 4'h0) begin
            addr_o         <= req_addr_i[13:7];
            op_q           <= req_op_i;
            din_o          <= req_wdata_i;
            row_strobe_n_o <= 1'b0;
            req_ready_o    <= 1'b1;
            state_q        <= S_RCD;
          end
        end
        S_RCD: begin
          if (tm.done) begin
            addr_o         <= req_addr_i[6:0];
            col_strobe_n_o <= 1'b0;
            if (op_q == 2'(DSQ_OP_WRITE)) begin
              write_n_o <= 1'b0;
              state_q   <= S_CAS;
            end else begin
              state_q <= S_WLATE;
            end
          end
        end
        S_WLATE: begin
          if (wlate_go) begin
            if (op_q == 2'(DSQ_OP_RMW)) begin
              rsp_rdata_o <= s3_q;
              rsp_valid_o <= 1'b1;
              write_n_o   <= 1'b0;
            end
            state_q <= S_WHOLD;
          end
        end
        S_CAS, S_WHOLD: begin
          if (cend_go) begin
            if (state_q == S_WHOLD && op_q == 2'(DSQ_OP_READ)) begin
              rsp_rdata_o <= s3_q;
              rsp_valid_o <= 1'b1;
            end
            col_strobe_n_o <= 1'b1;
            write_n_o      <= 1'b1;
            state_q        <= S_PAGE;
          end
        end
        S_PAGE: begin
          if (tm.done) begin
            if (page_go) begin
              addr_o         <= req_addr_i[6:0];
              op_q           <= req_op_i;
              din_o          <= req_wdata_i;
              col_strobe_n_o <= 1'b0;
              write_n_o      <= (req_op_i == 2'(DSQ_OP_WRITE)) ? 1'b0 : 1'b1;
              req_ready_o    <= 1'b1;
              state_q        <= (req_op_i == 2'(DSQ_OP_WRITE)) ? S_CAS
                              : S_WLATE;
            end else if (cyc_q >= CW'(C_RAS)) begin
              state_q <= S_CEND;
            end
          end
        end
        S_CEND: begin
          row_strobe_n_o <= 1'b1;
          state_q        <= S_RPRE;
        end
        S_REF: begin
          if (tm.done) begin
            row_strobe_n_o <= 1'b1;
            state_q        <= S_RPRE;
          end
        end
        S_RPRE: begin
          // Precharge plus elapsed pulse covers the full cycle time.
          if (tm.done && cyc_q >= CW'((op_q == 2'(DSQ_OP_RMW)) ? C_RMW
                                     : C_RC)) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// *** bench/dsq_checker.sv ***
module dsq_checker
  import dsq_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        resetn_i,
  input wire logic [13:0] req_addr_i,
  input wire logic        req_wdata_i,
  input wire logic        req_ready_o,
  input wire logic        row_strobe_n_o,
  input wire logic        col_strobe_n_o,
  input wire logic        write_n_o,
  input wire logic [6:0]  addr_o,
  input wire logic        din_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Interval counters.
  // ----------------------------------------------------------------
  // Counters saturate so that a long idle spell never wraps to a low value.
  logic [11:0] rc_q, ras_q, cc_q, ch_q, wl_q;
  logic        row_q, col_q, wr_q;
  wire row_fall = row_q & ~row_strobe_n_o;
  wire col_fall = col_q & ~col_strobe_n_o;
  wire wr_fall  = wr_q & ~write_n_o;
  function automatic logic [11:0] inc(input logic [11:0] v);
    return (&v) ? v : v + 12'h001;
  endfunction
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {row_q, col_q, wr_q} <= 3'h7;
      {rc_q, cc_q, ch_q} <= '1;
      {ras_q, wl_q} <= '0;
    end else begin
      {row_q, col_q, wr_q} <= {row_strobe_n_o, col_strobe_n_o, write_n_o};
      rc_q  <= row_fall ? 12'h001 : inc(rc_q);
      cc_q  <= col_fall ? 12'h001 : inc(cc_q);
      ras_q <= row_strobe_n_o ? 12'h000 : inc(ras_q);
      ch_q  <= col_strobe_n_o ? inc(ch_q) : 12'h000;
      wl_q  <= write_n_o ? 12'h000 : inc(wl_q);
    end
  end
  // ----------------------------------------------------------------
  // Properties.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  a_cycle_time_min: assert property (row_fall |-> rc_q >= C_RC)
    else $error("row cycles too close");
  a_page_cycle_min: assert property (col_fall |-> cc_q >= C_PC)
    else $error("column cycles too close");
  a_col_precharge_min: assert property (col_fall |-> ch_q >= C_CP)
    else $error("column precharge too short");
  a_row_col_delay: assert property (col_fall |-> ras_q >= C_RCD)
    else $error("column strobe too early");
  a_write_lead_time: assert property (
    (!col_q && col_strobe_n_o && !wr_q) |-> wl_q >= C_CWL)
    else $error("write lead too short");
  a_write_pulse_min: assert property (
    (!wr_q && write_n_o) |-> wl_q >= C_WP)
    else $error("write pulse too short");
  a_row_active_max: assert property (ras_q <= C_RAS_MAX)
    else $error("row strobe held too long");
  a_row_addr_mux: assert property (req_ready_o && row_q |->
    !row_strobe_n_o && addr_o == req_addr_i[13:7])
    else $error("row address wrong");
  a_data_in_timing: assert property ((col_fall && !write_n_o) ||
    (wr_fall && !col_strobe_n_o) |-> din_o == req_wdata_i)
    else $error("data in wrong at capture");
  c_early_write: cover property (col_fall && !write_n_o);
  c_late_write: cover property (wr_fall && !col_strobe_n_o);
  c_page_access: cover property (col_fall && ras_q > 12'd40);
endmodule

bind dsq_ctrl dsq_checker u_chk (.clock_i, .resetn_i, .req_addr_i,
  .req_wdata_i, .req_ready_o, .row_strobe_n_o, .col_strobe_n_o,
  .write_n_o, .addr_o, .din_o);

// *** bench/dsq_dram_model.sv ***
module dsq_dram_model (
  input  wire logic       row_strobe_n_i,
  input  wire logic       col_strobe_n_i,
  input  wire logic       write_n_i,
  input  wire logic [6:0] addr_i,
  input  wire logic       din_i,
  output logic            dout_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Cell array and strobe behaviour.
  // ----------------------------------------------------------------
  logic       mem [16384];
  logic [6:0] row_q, col_q;
  logic       rd_q, out_q = 1'b0, on_q = 1'b0, early_q = 1'b0;
  realtime    t_row, t_col, acc;
  int         warm_q = 0;
  // A released output shows the inverse of its last value, never a copy.
  assign dout_o = on_q ? out_q : ~out_q;
  always @(negedge row_strobe_n_i) begin
    row_q = addr_i;
    t_row = $realtime;
    if (warm_q < 8) warm_q++;
  end
  always @(negedge col_strobe_n_i) if (!row_strobe_n_i) begin
    col_q = addr_i;
    t_col = $realtime;
    early_q = !write_n_i;
    rd_q = mem[{row_q, col_q}] ^ (warm_q < 8);
    if (early_q) begin
      mem[{row_q, col_q}] = din_i;
    end else begin
      acc = (t_row + 200.0 > t_col + 135.0) ? t_row + 200.0
          : t_col + 135.0;
      #(acc - $realtime);
      if (!col_strobe_n_i) begin
        out_q = rd_q;
        on_q = 1'b1;
      end
    end
  end
  always @(negedge write_n_i) if (!row_strobe_n_i && !col_strobe_n_i) begin
    if (!early_q) begin
      mem[{row_q, col_q}] = din_i;
      if ($realtime - t_col < 80.0 || $realtime - t_row < 145.0) begin
        out_q = 1'bx;
        on_q = 1'b1;
      end
    end
  end
  always @(posedge col_strobe_n_i) on_q = 1'b0;
endmodule

// *** bench/tb_dram_16k_strobe_sequencing.sv ***
module tb_dram_16k_strobe_sequencing;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock_i, resetn_i, req_valid_i, req_wdata_i, req_page_i;
  logic [1:0]  req_op_i;
  logic [13:0] req_addr_i;
  logic        req_ready_o, rsp_valid_o, rsp_rdata_o, ready_o, din_o;
  logic        row_strobe_n_o, col_strobe_n_o, write_n_o;
  logic [6:0]  addr_o;
  wire logic   dout_i;
  int          err_total, comparisons;
  // Short refresh spacing keeps the idle scenario brief.
  dsq_ctrl #(.REF_ROW_CYCLES(200)) dut (.clock_i, .resetn_i, .req_valid_i,
    .req_op_i, .req_addr_i, .req_wdata_i, .req_page_i, .req_ready_o,
    .rsp_valid_o, .rsp_rdata_o, .ready_o, .row_strobe_n_o, .col_strobe_n_o,
    .write_n_o, .addr_o, .din_o, .dout_i);
  dsq_dram_model u_mem (.row_strobe_n_i(row_strobe_n_o),
    .col_strobe_n_i(col_strobe_n_o), .write_n_i(write_n_o), .addr_i(addr_o),
    .din_i(din_o), .dout_o(dout_i));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  task automatic chk(input logic got, input logic want, input string msg);
    comparisons++;
    if (got !== want) begin
      err_total++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Holds the request fields until the column strobe has risen again.
  task automatic op(input logic [1:0] k, input logic [13:0] a,
                    input logic wd, input logic pg, input logic want);
    logic got, seen, low;
    {got, seen, low} = 3'h0;
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_op_i <= k;
    req_addr_i <= a;
    req_wdata_i <= wd;
    req_page_i <= pg;
    repeat (300) begin
      @(posedge clock_i);
      if (req_ready_o === 1'b1) break;
    end
    chk(req_ready_o, 1'b1, "request not taken");
    req_valid_i <= 1'b0;
    repeat (300) begin
      @(posedge clock_i);
      if (rsp_valid_o === 1'b1) begin
        seen = 1'b1;
        got = rsp_rdata_o;
      end
      low = low | (col_strobe_n_o === 1'b0);
      if (low && col_strobe_n_o === 1'b1 && (seen || k == 2'h1)) break;
    end
    if (k != 2'h1) chk(got, want, "read data");
  endtask
  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_warmup();
    int n;
    logic prev;
    n = 0;
    prev = 1'b1;
    repeat (2000) begin
      @(posedge clock_i);
      if (ready_o === 1'b1) break;
      if (req_ready_o !== 1'b0 || col_strobe_n_o !== 1'b1) n = 99;
      if (prev && !row_strobe_n_o) n++;
      prev = row_strobe_n_o;
    end
    chk(n == 8, 1'b1, "warm-up cycle count");
  endtask
  task automatic t_write_read();
    op(2'h1, 14'h0000, 1'b1, 1'b0, 1'b0);
    op(2'h1, 14'h3fff, 1'b1, 1'b0, 1'b0);
    op(2'h1, 14'h007f, 1'b0, 1'b0, 1'b0);
    op(2'h0, 14'h0000, 1'b0, 1'b0, 1'b1);
    op(2'h0, 14'h3fff, 1'b0, 1'b0, 1'b1);
    op(2'h0, 14'h007f, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_rmw();
    op(2'h2, 14'h0000, 1'b0, 1'b0, 1'b1);
    op(2'h0, 14'h0000, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_page();
    op(2'h1, 14'h1205, 1'b1, 1'b0, 1'b0);
    op(2'h1, 14'h1207, 1'b1, 1'b1, 1'b0);
    op(2'h0, 14'h1205, 1'b0, 1'b1, 1'b1);
    op(2'h0, 14'h007f, 1'b0, 1'b0, 1'b0);
    op(2'h0, 14'h1207, 1'b0, 1'b0, 1'b1);
  endtask
  task automatic t_refresh();
    int n;
    logic prev, colact;
    {n, prev, colact} = {32'h0, 1'b1, 1'b0};
    repeat (1000) begin
      @(posedge clock_i);
      if (prev && !row_strobe_n_o) n++;
      prev = row_strobe_n_o;
      colact = colact | (col_strobe_n_o !== 1'b1);
    end
    chk(n >= 4 && n <= 6 && !colact, 1'b1, "idle refresh count");
  endtask
  initial begin
    {resetn_i, req_valid_i, req_wdata_i, req_page_i} = 4'h0;
    req_op_i = 2'h0;
    req_addr_i = 14'h0000;
    err_total = 0;
    comparisons = 0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_warmup();
    t_write_read();
    t_rmw();
    t_page();
    t_refresh();
    close_out();
  end
  initial begin
    #100000;
    err_total++;
    $display("FAIL %0t watchdog expired", $time);
    close_out();
  end
endmodule
